// >>> inc/fir_pkg.sv
// fir coprocessor constants and port map
`default_nettype none
package fir_pkg;
  localparam int          FIR_AW         = 8;   // port address width
  localparam int          FIR_DW         = 16;  // port data width
  localparam int          FIR_MEM_AW     = 10;
  localparam int          FIR_COEF_W     = 18;
  localparam int          FIR_ACC_W      = 34;
  localparam int          FIR_ACC_N      = 8;   // 1 + interpolation max 7
  localparam logic [7:0]  FIR_A_SAMPLE   = 8'h28;
  localparam logic [7:0]  FIR_A_COEF_LO  = 8'h29;
  localparam logic [7:0]  FIR_A_COEF_HI  = 8'h2a;
  localparam logic [7:0]  FIR_A_TAPS     = 8'h2b;
  localparam logic [7:0]  FIR_A_BUF      = 8'h2c;
  localparam logic [7:0]  FIR_A_LAUNCH   = 8'h2d;
  localparam logic [7:0]  FIR_A_PCLR     = 8'h2e;
  localparam logic [7:0]  FIR_A_FLAGS    = 8'h2f;
  localparam int          FIR_TAPS_LSB   = 0;   // taps field 7:0
  localparam int          FIR_INTRP_LSB  = 8;   // interpolation 10:8
  localparam int          FIR_BASE_LSB   = 0;   // data base 4:0
  localparam int          FIR_LEN_LSB    = 5;   // length code 6:5
  localparam int          FIR_RDY_BIT    = 0;
  localparam int          FIR_OVF_BIT    = 15;
  localparam int          FIR_UNIT_LOG2  = 5;   // 32-entry buffer units
  localparam logic [15:0] FIR_RD_IDLE    = 16'h0000;
endpackage
`default_nettype wire

// >>> inc/fir_if.sv
// port bus between soft cpu and fir coprocessor
`default_nettype none
interface fir_if (
  input wire logic mclk,
  input wire logic nrst
);
  import fir_pkg::*;
  logic [FIR_AW-1:0] addr;
  logic [FIR_DW-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [FIR_DW-1:0] rdata;
  modport cpu (input mclk, nrst, rdata, output addr, wdata, wr, rd);
  modport dev (input mclk, nrst, addr, wdata, wr, rd, output rdata);
endinterface
`default_nettype wire

// >>> rtl/fir_host.sv
// cpu side: forwards port accesses from user logic onto the bus
`default_nettype none
module fir_host (
  // bus
  fir_if.cpu                        bus,
  // user command
  input  wire logic [7:0]           u_addr,
  input  wire logic [15:0]          u_wdata,
  input  wire logic                 u_wr,
  input  wire logic                 u_rd,
  // user answer
  output logic      [15:0]          u_rdata,
  output logic                      u_rvalid
);
  import fir_pkg::*;
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        rpend;
    logic [15:0] rdata;
    logic        rvalid;
  } fir_host_s;
  fir_host_s st_ff;
  fir_host_s nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // ordering is software's duty; strobes registered, one per command
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.addr   = u_addr;
    nxt_st.wdata  = u_wdata;
    nxt_st.wr     = u_wr & ~u_rd;   // never both strobes at once
    nxt_st.rd     = u_rd;
    nxt_st.rpend  = st_ff.rd;
    nxt_st.rvalid = st_ff.rpend;
    if (st_ff.rpend) begin
      nxt_st.rdata = bus.rdata;
    end
    if (!bus.nrst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge bus.mclk) begin
    st_ff <= nxt_st;
  end

  assign bus.addr  = st_ff.addr;
  assign bus.wdata = st_ff.wdata;
  assign bus.wr    = st_ff.wr;
  assign bus.rd    = st_ff.rd;
  assign u_rdata   = st_ff.rdata;
  assign u_rvalid  = st_ff.rvalid;
endmodule
`default_nettype wire

// >>> rtl/fir_dev.sv
// fir coprocessor engine with shared ram and port registers
`default_nettype none
module fir_dev (
  // bus
  fir_if.dev                        bus,
  // user side status
  output logic                      busy,
  output logic                      overflow_flag
);
  import fir_pkg::*;

  typedef struct packed {
    logic [1:0]            coef_hi;   // held upper coefficient bits
    logic [9:0]            actr;      // coefficient load counter
    logic [7:0]            taps;
    logic [2:0]            intrp;
    logic [4:0]            dbase;
    logic [1:0]            dlen;
    logic                  run;
    logic [9:0]            caddr;
    logic [7:0]            dindx;
    logic [7:0]            cctr;
    logic [2:0]            dint;
    logic [FIR_ACC_N-1:0]  rstacc;    // load-instead-of-add delay line
    logic                  pvalid;    // memory read in flight
    logic                  pfirst;
    logic                  ovf;
    logic [15:0]           rdata;
  } fir_dev_s;

  fir_dev_s st_ff;
  fir_dev_s nxt_st;

  // single dual-port memory, 18-bit words hold data or coefficients
  logic [FIR_COEF_W-1:0] mem [0:(1<<FIR_MEM_AW)-1];
  logic [7:0]            dctr [0:15];   // sixteen write counters
  logic [FIR_ACC_W-1:0]  acc_ff [0:FIR_ACC_N-1];
  logic [FIR_COEF_W-1:0] rd_c_ff;
  logic [FIR_COEF_W-1:0] rd_d_ff;

  logic                  wr_sample;
  logic                  wr_coef;
  logic [9:0]            waddr;
  logic [9:0]            daddr;
  logic [7:0]            wcnt;
  logic signed [FIR_ACC_W-1:0] prod;
  logic signed [FIR_ACC_W-1:0] fb;
  logic signed [FIR_ACC_W:0]   sum;
  logic                  sum_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // merge counter bits with the aligned buffer base
  function automatic logic [9:0] buf_addr(input logic [4:0] base,
                                          input logic [1:0] len,
                                          input logic [7:0] cnt);
    logic [9:0] mask;
    // low 5+len address bits come from the counter, the rest from base
    mask = (10'h020 << len) - 10'h001;
    return ({base, 5'h00} & ~mask) | ({2'h0, cnt} & mask);
  endfunction

  assign wr_sample = bus.wr && bus.addr == FIR_A_SAMPLE;
  assign wr_coef   = bus.wr && bus.addr == FIR_A_COEF_LO;
  assign wcnt      = dctr[st_ff.dbase[4:1]];
  // write pointer: load counter for coefficients, else chosen by current base setting
  assign waddr     = wr_coef ? st_ff.actr
                             : buf_addr(st_ff.dbase, st_ff.dlen, wcnt);
  assign daddr     = buf_addr(st_ff.dbase, st_ff.dlen, st_ff.dindx);

  ////////////////////////////////////////////////////////////////////////////
  // port a: cpu writes; port b: engine reads both streams
  always_ff @(posedge bus.mclk) begin
    if (wr_sample) begin
      mem[waddr] <= {{2{bus.wdata[15]}}, bus.wdata};
    end else if (wr_coef) begin
      // joins held high bits with low word
      mem[waddr] <= {st_ff.coef_hi, bus.wdata};
    end
    rd_c_ff <= mem[st_ff.caddr];
    rd_d_ff <= mem[daddr];
  end

  // per-buffer counter advances after each sample write; cleared by
  // reset, else an unknown pointer would never resolve on increment
  always_ff @(posedge bus.mclk) begin
    if (!bus.nrst) begin
      for (int i = 0; i < 16; i++) begin
        dctr[i] <= 8'h00;
      end
    end else if (wr_sample) begin
      dctr[st_ff.dbase[4:1]] <= wcnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiply one tap per clock; first 1+intrp products load
  assign prod = FIR_ACC_W'(signed'(rd_c_ff) * signed'(rd_d_ff[15:0]));
  assign fb   = st_ff.pfirst ? '0 : signed'(acc_ff[st_ff.intrp]);
  assign sum  = {prod[FIR_ACC_W-1], prod} + {fb[FIR_ACC_W-1], fb};
  assign sum_ovf = sum[FIR_ACC_W] != sum[FIR_ACC_W-1];

  // accumulator shift register, length 1 + interpolation
  always_ff @(posedge bus.mclk) begin
    if (st_ff.pvalid) begin
      acc_ff[0] <= sum[FIR_ACC_W-1:0];
      for (int i = 1; i < FIR_ACC_N; i++) begin
        acc_ff[i] <= acc_ff[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control state
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.pvalid = st_ff.run;
    nxt_st.pfirst = st_ff.rstacc[0] & st_ff.run;
    nxt_st.rdata  = FIR_RD_IDLE;
    if (bus.wr) begin
      case (bus.addr)
        FIR_A_COEF_HI: nxt_st.coef_hi = bus.wdata[1:0];
        // load counter steps on low write
        FIR_A_COEF_LO: nxt_st.actr = st_ff.actr + 10'h001;
        FIR_A_TAPS: begin
          // up to 255 taps, interpolation up to 7
          nxt_st.taps  = bus.wdata[FIR_TAPS_LSB +: 8];
          nxt_st.intrp = bus.wdata[FIR_INTRP_LSB +: 3];
        end
        FIR_A_BUF: begin
          nxt_st.dbase = bus.wdata[FIR_BASE_LSB +: 5];
          nxt_st.dlen  = bus.wdata[FIR_LEN_LSB +: 2];
        end
        FIR_A_LAUNCH: begin
          nxt_st.caddr  = bus.wdata[9:0];
          // index starts one below write pointer
          nxt_st.dindx  = wcnt - 8'h01;
          nxt_st.cctr   = st_ff.taps;
          nxt_st.run    = st_ff.taps != 8'h00;
          nxt_st.dint   = 3'h0;
          // delay line marks first 1+intrp products as loads
          nxt_st.rstacc = FIR_ACC_N'((16'h0002 << st_ff.intrp) - 16'h0001);
          nxt_st.ovf    = 1'b0;
        end
        FIR_A_PCLR: nxt_st.actr = 10'h000;
        default: ;
      endcase
    end
    if (st_ff.run) begin
      nxt_st.caddr  = st_ff.caddr + 10'h001;
      nxt_st.cctr   = st_ff.cctr - 8'h01;
      nxt_st.rstacc = {1'b0, st_ff.rstacc[FIR_ACC_N-1:1]};
      // interpolation counter wraps at setting, data steps on wrap
      if (st_ff.dint == st_ff.intrp) begin
        nxt_st.dint  = 3'h0;
        nxt_st.dindx = st_ff.dindx - 8'h01;
      end else begin
        nxt_st.dint  = st_ff.dint + 3'h1;
      end
      if (st_ff.cctr == 8'h01) begin
        nxt_st.run = 1'b0;
      end
    end
    // sticky overflow; set beats the launch clear
    if (st_ff.pvalid && sum_ovf) begin
      nxt_st.ovf = 1'b1;
    end
    if (bus.rd) begin
      if (bus.addr >= FIR_A_SAMPLE && bus.addr < FIR_A_FLAGS) begin
        // result ports read accumulator entries, top 16 bits
        nxt_st.rdata = acc_ff[3'(bus.addr - FIR_A_SAMPLE)][33:18];
      end else if (bus.addr == FIR_A_FLAGS) begin
        nxt_st.rdata[FIR_RDY_BIT] = ~(st_ff.run | st_ff.pvalid);
        nxt_st.rdata[FIR_OVF_BIT] = st_ff.ovf;
      end
    end
    if (!bus.nrst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge bus.mclk) begin
    st_ff <= nxt_st;
  end

  assign bus.rdata     = st_ff.rdata;
  assign busy          = st_ff.run | st_ff.pvalid;
  assign overflow_flag = st_ff.ovf;
endmodule
`default_nettype wire

// >>> tb/fir_chk.sv
// bus and status assertions for the fir host and coprocessor pair
`default_nettype none
module fir_chk
  import fir_pkg::*;
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              nrst,
  // bus
  input wire logic [FIR_AW-1:0] addr,
  input wire logic [FIR_DW-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [FIR_DW-1:0] rdata,
  // engine status
  input wire logic              busy,
  input wire logic              overflow_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tap_ff;
  logic [9:0] bcnt_ff;
  logic       launch;
  //////////////////////////////////////////
  // tap count shadow and busy length, so run time can be judged
  assign launch = wr && (addr == FIR_A_LAUNCH);
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tap_ff <= 8'h00;
      bcnt_ff <= 10'h000;
    end else begin
      if (wr && addr == FIR_A_TAPS) begin
        tap_ff <= wdata[7:0];
      end
      bcnt_ff <= busy ? bcnt_ff + 10'h001 : 10'h000;
    end
  end
  //////////////////////////////////////////
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  chk_rdata_idle: assert property (
    !$past(rd) |-> rdata == FIR_RD_IDLE)
    else $error("read data not idle outside a read answer");
  chk_flags_clean: assert property (
    rd && addr == FIR_A_FLAGS |=> rdata[14:1] == 14'h0000)
    else $error("unused status bits not zero");
  chk_launch_busy: assert property (
    launch && tap_ff != 8'h00 && !busy |-> ##[1:2] busy)
    else $error("launch did not start the engine");
  chk_tap_count: assert property (
    $fell(busy) |-> bcnt_ff == {2'h0, tap_ff} + 10'h001)
    else $error("busy time does not match tap count");
  chk_busy_quiet: assert property (
    !busy && !launch |=> !busy)
    else $error("engine started without a launch");
  chk_ovf_launch: assert property (
    $fell(overflow_flag) |-> $past(launch) || $past(launch, 2))
    else $error("overflow cleared without a launch");
  chk_ovf_source: assert property (
    $rose(overflow_flag) |-> busy || $past(busy) || $past(busy, 2))
    else $error("overflow raised while idle");
  chk_strobe_excl: assert property (
    !(wr && rd))
    else $error("read and write strobes together");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the fir host and coprocessor pair
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fir_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  u_addr = 8'h00;
  logic [15:0] u_wdata = 16'h0000;
  logic        u_wr = 1'b0;
  logic        u_rd = 1'b0;
  logic [15:0] u_rdata;
  logic        u_rvalid;
  logic        busy;
  logic        overflow_flag;
  logic [15:0] rv;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  //////////////////////////////////////////
  // 25 mhz clock and the two ends joined by the bus
  always #20 mclk = ~mclk;
  fir_if bus (.mclk(mclk), .nrst(nrst));
  fir_host i_fir_host (.bus(bus), .u_addr(u_addr), .u_wdata(u_wdata),
    .u_wr(u_wr), .u_rd(u_rd), .u_rdata(u_rdata), .u_rvalid(u_rvalid));
  fir_dev i_fir_dev (.bus(bus), .busy(busy),
    .overflow_flag(overflow_flag));
  fir_chk i_fir_chk (.mclk(mclk), .nrst(nrst), .addr(bus.addr),
    .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
    .busy(busy), .overflow_flag(overflow_flag));
  //////////////////////////////////////////
  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  // one write, with a gap so the strobe is never set twice in a step
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    u_addr <= a;
    u_wdata <= d;
    u_wr <= 1'b1;
    @(posedge mclk);
    u_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // one read, waiting a bounded time for the answer pulse
  task automatic get(input logic [7:0] a, output logic [15:0] d);
    int n;
    n = 0;
    u_addr <= a;
    u_rd <= 1'b1;
    @(posedge mclk);
    u_rd <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (u_rvalid !== 1'b1 && n < 8);
    d = (u_rvalid === 1'b1) ? u_rdata : 16'hxxxx;
  endtask
  // idle status after reset and an unmapped read
  task automatic s_idle();
    get(FIR_A_FLAGS, rv);
    check(rv, 16'h0001);
    get(8'h10, rv);
    check(rv, 16'h0000);
  endtask
  // full 31-tap pass on a 32-entry buffer at base 16 (address 512)
  task automatic s_pass(input logic [15:0] hi, input logic [15:0] lo,
    input logic [15:0] smp, input logic [15:0] res,
    input logic [15:0] flg, input logic use_res);
    int i;
    put(FIR_A_PCLR, 16'h0000);
    for (i = 0; i < 31; i++) begin
      put(FIR_A_COEF_HI, hi);
      put(FIR_A_COEF_LO, lo);
    end
    put(FIR_A_BUF, 16'h0010);
    put(FIR_A_TAPS, 16'h001f);
    for (i = 0; i < 32; i++) begin
      put(FIR_A_SAMPLE, smp);
    end
    put(FIR_A_LAUNCH, 16'h0000);
    rv = 16'h0000;
    for (i = 0; i < 40 && rv[0] !== 1'b1; i++) begin
      get(FIR_A_FLAGS, rv);
    end
    check(rv, flg);
    get(FIR_A_SAMPLE, rv);
    if (use_res) begin
      check(rv, res);
    end
  endtask
  // 2x interpolation, 256-entry buffer at base 8 (address 256), coefficient
  // set appended at 31 with value -131072; samples 4,8..64. even phase sums
  // all 16 samples (544), odd phase skips the oldest (540): bits 33:18 give
  // -272 and -270
  task automatic s_interp();
    int i;
    for (i = 0; i < 31; i++) begin
      put(FIR_A_COEF_HI, 16'h0002);
      put(FIR_A_COEF_LO, 16'h0000);
    end
    put(FIR_A_BUF, 16'h0068);
    put(FIR_A_TAPS, 16'h011f);
    for (i = 0; i < 16; i++) begin
      put(FIR_A_SAMPLE, 16'(4 * (i + 1)));
    end
    put(FIR_A_LAUNCH, 16'h001f);
    rv = 16'h0000;
    for (i = 0; i < 40 && rv[0] !== 1'b1; i++) begin
      get(FIR_A_FLAGS, rv);
    end
    check(rv, 16'h0001);
    get(FIR_A_SAMPLE, rv);
    check(rv, 16'hfef0);
    get(FIR_A_COEF_LO, rv);
    check(rv, 16'hfef2);
  endtask
  //////////////////////////////////////////
  // main sequence: overflow pass, a clean pass that clears it, then
  // interpolation on a long buffer
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    s_idle();
    s_pass(16'h0001, 16'hffff, 16'h7fff, 16'h0000, 16'h8001, 1'b0);
    s_pass(16'h0001, 16'h0000, 16'h0004, 16'h001f, 16'h0001, 1'b1);
    s_interp();
    end_of_test();
  end
  // hang guard, far above the few hundred cycles a pass needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      end_of_test();
    end
  end
endmodule
`default_nettype wire
